// ===== verilog/pmt8_pkg.sv
`default_nettype none

// shared constants of the period match timer
package pmt8_pkg;

   // register port geometry
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned PRE_W  = 4;
   localparam int unsigned POST_W = 4;

   // register addresses
   localparam logic [ADDR_W-1:0] ADDR_COUNT   = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_CONTROL = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_PERIOD  = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_IRQ     = 4'h3;

   // timer_control field positions
   localparam int unsigned CTL_PRE_LSB  = 0;
   localparam int unsigned CTL_PRE_MSB  = 1;
   localparam int unsigned CTL_RUN_BIT  = 2;
   localparam int unsigned CTL_POST_LSB = 3;
   localparam int unsigned CTL_POST_MSB = 6;

   // interrupt register field positions
   localparam int unsigned IRQ_FLAG_BIT = 0;
   localparam int unsigned IRQ_EN_BIT   = 1;

   // reset values
   localparam logic [DATA_W-1:0] COUNT_RST   = 8'h00;
   localparam logic [DATA_W-1:0] CONTROL_RST = 8'h00;
   localparam logic [DATA_W-1:0] PERIOD_RST  = 8'hFF;
   localparam logic [DATA_W-1:0] READ_ZERO   = 8'h00;
   localparam logic [POST_W-1:0] POST_RST    = 4'h0;
   localparam logic [PRE_W-1:0]  PRE_RST     = 4'h0;

   // implemented bits of timer_control, top bit absent
   localparam logic [DATA_W-1:0] CONTROL_MASK = 8'h7F;

   // prescale select codes and their last count
   localparam logic [1:0]       PRE_SEL_DIV1  = 2'h0;
   localparam logic [1:0]       PRE_SEL_DIV4  = 2'h1;
   localparam logic [PRE_W-1:0] PRE_TERM_DIV1 = 4'h0;
   localparam logic [PRE_W-1:0] PRE_TERM_DIV4 = 4'h3;
   localparam logic [PRE_W-1:0] PRE_TERM_DIV16 = 4'hF;

   // single step of any counter
   localparam logic [DATA_W-1:0] STEP8 = 8'h01;
   localparam logic [PRE_W-1:0]  STEP4 = 4'h1;

endpackage : pmt8_pkg

`default_nettype wire

// ===== verilog/pmt8_prescaler.sv
`timescale 1ns/1ps
`default_nettype none

// divides the instruction clock by 1, 4 or 16 ahead of the counter
module pmt8_prescaler (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       srst,
   // control
   input  wire logic       clear,
   input  wire logic       run,
   input  wire logic [1:0] sel,
   // one-cycle advance request
   output logic            tick
);

   // last count for a select code; 1x both mean sixteen
   function automatic logic [pmt8_pkg::PRE_W-1:0] pmt8_term(input logic [1:0] s);
      if (s == pmt8_pkg::PRE_SEL_DIV1) begin
         return pmt8_pkg::PRE_TERM_DIV1;
      end else if (s == pmt8_pkg::PRE_SEL_DIV4) begin
         return pmt8_pkg::PRE_TERM_DIV4;
      end else begin
         return pmt8_pkg::PRE_TERM_DIV16;
      end
   endfunction : pmt8_term

   logic [pmt8_pkg::PRE_W-1:0] cnt;       // instruction cycles seen
   logic [pmt8_pkg::PRE_W-1:0] next_cnt;  // following value
   logic                       at_term;   // last cycle of a group

   assign at_term  = (cnt == pmt8_term(sel));
   assign tick     = run & at_term; // RULE_01 RULE_03
   assign next_cnt = at_term ? pmt8_pkg::PRE_RST : cnt + pmt8_pkg::STEP4;

   // stopped timer holds its phase, costing no toggles
   always_ff @(posedge ref_clk) begin
      if (srst || clear) begin
         cnt <= pmt8_pkg::PRE_RST; // RULE_08
      end else if (run) begin
         cnt <= next_cnt; // RULE_01
      end
   end

endmodule : pmt8_prescaler

`default_nettype wire

// ===== verilog/pmt8_timer.sv
//
// Operation
// RULE_01: prescaler divides by 1, 4 or 16
// RULE_02: postscale field n gives ratio 1:(n+1)
// RULE_03: counter advances only while run bit set
// RULE_04: count to period, then wrap to zero
// RULE_05: period register resets to all ones
// RULE_06: count register readable, writable, reset clears
// RULE_07: postscaler terminal sets timer interrupt flag
// RULE_08: count/control writes, reset clear both scalers
// RULE_09: control write keeps the count value
// RULE_10: control resets to zero, timer off
// RULE_11: raw match pulse goes to serial port
// RULE_12: match and wrap feed PWM time base
// RULE_13: control top bit reads zero, ignores writes
// RULE_14: flag sticky; request only while enabled
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module pmt8_timer (
   // clock and reset
   input  wire logic                          ref_clk,
   input  wire logic                          srst,
   // register port
   input  wire logic [pmt8_pkg::ADDR_W-1:0]   reg_addr,
   input  wire logic [pmt8_pkg::DATA_W-1:0]   reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output logic      [pmt8_pkg::DATA_W-1:0]   reg_rdata,
   // serial port shift clock source
   output logic                               sync_serial_port_tick,
   // pwm time base
   output logic                               pwm_period_wrap,
   output logic      [pmt8_pkg::DATA_W-1:0]   pwm_count,
   // interrupt
   output logic                               match_irq_flag,
   output logic                               match_irq_req
);

   // true when a strobe addresses the given register
   // shared by the four write decodes
   function automatic logic pmt8_hit(
      input logic                        strobe,
      input logic [pmt8_pkg::ADDR_W-1:0] addr,
      input logic [pmt8_pkg::ADDR_W-1:0] target
   );
      return strobe && (addr == target);
   endfunction : pmt8_hit

   // ---- register state ----
   // every register below runs on every clock edge
   logic [pmt8_pkg::DATA_W-1:0] timer_count;    // live count
   logic [pmt8_pkg::DATA_W-1:0] timer_control;  // mode and run bit
   logic [pmt8_pkg::DATA_W-1:0] period_value;   // wrap point
   logic                        match_irq_enable; // request gate
   logic [pmt8_pkg::POST_W-1:0] post_cnt;       // matches seen

   // ---- next values ----
   // combinational, settled well before each edge
   logic [pmt8_pkg::DATA_W-1:0] next_count;     // count after edge
   logic [pmt8_pkg::POST_W-1:0] next_post;      // postscaler after edge
   logic                        next_flag;      // flag after edge
   logic                        next_enable;    // enable after edge
   logic [pmt8_pkg::DATA_W-1:0] next_rdata;     // read data after edge

   // ---- decoded strobes ----
   // high in the same cycle as the bus strobe
   wire wr_count;                                // write to count
   wire wr_control;                              // write to control
   wire wr_period;                               // write to period
   wire wr_irq;                                  // write to irq register
   wire scaler_clear;                            // wipe both scalers

   // ---- control fields ----
   // taken from the stored register only
   wire                        run_enable;       // counter may advance
   wire [1:0]                  prescale_select;  // 1, 4 or 16
   wire [pmt8_pkg::POST_W-1:0] postscale_select; // ratio minus one

   // ---- timing events ----
   // combinational, none registered; at_period is a level, not a pulse
   wire pre_tick;                                // prescaler done
   wire advance;                                 // counter steps now
   wire at_period;                               // count equals period
   wire period_hit;                              // match and wrap
   wire post_hit;                                // postscaler done

   // ---- read path ----
   // selection first, then one output flop
   wire [pmt8_pkg::DATA_W-1:0] irq_view;         // flag and enable bits
   wire [pmt8_pkg::DATA_W-1:0] rd_mux;           // addressed register

   // address decode
   // each decode compares reg_addr with its own address, so at most
   // one of these is high at any edge
   assign wr_count   = pmt8_hit(reg_wr, reg_addr, pmt8_pkg::ADDR_COUNT);
   assign wr_control = pmt8_hit(reg_wr, reg_addr, pmt8_pkg::ADDR_CONTROL);
   assign wr_period  = pmt8_hit(reg_wr, reg_addr, pmt8_pkg::ADDR_PERIOD);
   assign wr_irq     = pmt8_hit(reg_wr, reg_addr, pmt8_pkg::ADDR_IRQ);

   // either register write restarts the scaler phases
   // a period or irq write leaves them running
   assign scaler_clear = wr_count | wr_control; // RULE_08

   // field extraction
   // bit 7 is never stored, so it has no field
   assign run_enable       = timer_control[pmt8_pkg::CTL_RUN_BIT]; // RULE_03
   assign prescale_select  = timer_control[pmt8_pkg::CTL_PRE_MSB:pmt8_pkg::CTL_PRE_LSB];
   assign postscale_select = timer_control[pmt8_pkg::CTL_POST_MSB:pmt8_pkg::CTL_POST_LSB];

   // prescaler on the instruction clock
   // each ref_clk edge counts as one instruction cycle;
   // stopping holds the phase, a count or control write restarts it
   pmt8_prescaler u_prescaler (
      .ref_clk (ref_clk),
      .srst    (srst),
      .clear   (scaler_clear),
      .run     (run_enable),
      .sel     (prescale_select),
      .tick    (pre_tick)
   );

   // a tick landing on a count or control write is dropped:
   // the write restarts the prescaler group anyway
   assign advance = pre_tick & ~scaler_clear; // RULE_03 RULE_08

   // equality test, not overflow: a period below the count
   // lets the count run to FFh and roll through zero
   assign at_period  = (timer_count == period_value); // RULE_04
   assign period_hit = advance & at_period; // RULE_04

   // postscaler terminal when the match count equals the field
   // field n therefore needs n+1 matches per flag
   assign post_hit = period_hit & (post_cnt == postscale_select); // RULE_02 RULE_07

   // count next value
   // priority: software write, wrap, step, hold
   always_comb begin
      if (wr_count) begin
         // software write wins over a step
         next_count = reg_wdata; // RULE_06
      end else if (period_hit) begin
         // wrap instead of passing the period
         next_count = pmt8_pkg::COUNT_RST; // RULE_04
      end else if (advance) begin
         // plain step
         next_count = timer_count + pmt8_pkg::STEP8; // RULE_04
      end else begin
         // hold, also on control writes
         next_count = timer_count; // RULE_09
      end
   end

   // postscaler next value
   // clear and terminal both return it to zero
   always_comb begin
      if (scaler_clear) begin
         // restart from zero matches
         next_post = pmt8_pkg::POST_RST; // RULE_08
      end else if (post_hit) begin
         // group of n+1 matches complete
         next_post = pmt8_pkg::POST_RST; // RULE_02
      end else if (period_hit) begin
         // one more match seen
         next_post = post_cnt + pmt8_pkg::STEP4; // RULE_07
      end else begin
         // no match this cycle
         next_post = post_cnt;
      end
   end

   // interrupt flag and enable next values
   // writing bit 0 high sets the flag from software,
   // handy for exercising a handler
   always_comb begin
      if (wr_irq) begin
         // software may clear or set the flag by writing
         next_flag   = reg_wdata[pmt8_pkg::IRQ_FLAG_BIT];
         next_enable = reg_wdata[pmt8_pkg::IRQ_EN_BIT];
      end else begin
         // flag stays put until software acts
         next_flag   = match_irq_flag; // RULE_14
         next_enable = match_irq_enable;
      end
      // a hardware set beats a clear in the same cycle
      if (post_hit) begin
         next_flag = 1'b1; // RULE_07
      end
   end

   // read view of the interrupt register, other bits zero
   // bits above the enable are reserved
   assign irq_view = {{(pmt8_pkg::DATA_W-2){1'b0}}, match_irq_enable, match_irq_flag};

   // read selection; unmapped addresses read zero
   // reading has no side effect on any register
   assign rd_mux =
      (reg_addr == pmt8_pkg::ADDR_COUNT)   ? timer_count :
      (reg_addr == pmt8_pkg::ADDR_CONTROL) ? (timer_control & pmt8_pkg::CONTROL_MASK) : // RULE_13
      (reg_addr == pmt8_pkg::ADDR_PERIOD)  ? period_value :
      (reg_addr == pmt8_pkg::ADDR_IRQ)     ? irq_view :
      pmt8_pkg::READ_ZERO;

   // read data exists only in the cycle after a read strobe
   // a late sample therefore sees 00h, not stale data
   assign next_rdata = reg_rd ? rd_mux : pmt8_pkg::READ_ZERO;

   // count register
   // one srst stands for every kind of reset
   // a write lands here even while stopped
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         timer_count <= pmt8_pkg::COUNT_RST; // RULE_06
      end else begin
         timer_count <= next_count;
      end
   end

   // control register; top bit never stored
   // the write also restarts both scalers
   // but leaves the count where it was
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         timer_control <= pmt8_pkg::CONTROL_RST; // RULE_10
      end else if (wr_control) begin
         timer_control <= reg_wdata & pmt8_pkg::CONTROL_MASK; // RULE_13
      end
   end

   // period register
   // a new period acts at the next compare;
   // one below the count forces a rollover first
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         period_value <= pmt8_pkg::PERIOD_RST; // RULE_05
      end else if (wr_period) begin
         period_value <= reg_wdata;
      end
   end

   // postscaler counter
   // matches seen since the flag was last set
   // restarted by count and control writes
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         post_cnt <= pmt8_pkg::POST_RST; // RULE_08
      end else begin
         post_cnt <= next_post;
      end
   end

   // flag and enable
   // the flag is sticky: only software or a
   // postscaler terminal changes it
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         match_irq_flag   <= 1'b0;
         match_irq_enable <= 1'b0;
      end else begin
         match_irq_flag   <= next_flag;
         match_irq_enable <= next_enable;
      end
   end

   // request follows flag and enable in the same cycle
   // built from the next values so that it never
   // trails the flag by a cycle
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         match_irq_req <= 1'b0;
      end else begin
         match_irq_req <= next_flag & next_enable; // RULE_14
      end
   end

   // raw match, ahead of the postscaler, to the serial port
   // and the pwm time base; one cycle per wrap
   // the serial port may toggle its shift clock on it
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sync_serial_port_tick <= 1'b0;
         pwm_period_wrap       <= 1'b0;
      end else begin
         sync_serial_port_tick <= period_hit; // RULE_11
         pwm_period_wrap       <= period_hit; // RULE_12
      end
   end

   // registered read data
   // kept apart from the mux so the output is a flop
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         reg_rdata <= pmt8_pkg::READ_ZERO;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

   // pwm compares against the live count flop directly
   // a copy flop would lag the wrap pulse by a cycle
   assign pwm_count = timer_count; // RULE_12

endmodule : pmt8_timer

`default_nettype wire

// ===== tb/pmt8_timer_props.sv
`timescale 1ns/1ps
`default_nettype none

// watches the timer ports against shadows of what software wrote
module pmt8_timer_props (
   // clock and reset
   input wire logic       ref_clk,
   input wire logic       srst,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   // timer events
   input wire logic       sync_serial_port_tick,
   input wire logic       pwm_period_wrap,
   input wire logic [7:0] pwm_count,
   input wire logic       match_irq_flag,
   input wire logic       match_irq_req
);
   logic [7:0] ctl;                                 // control shadow
   logic [7:0] per;                                 // period shadow
   logic       en;                                  // irq enable shadow
   wire        wcnt = reg_wr && reg_addr == 4'h0;   // count write
   wire        wctl = reg_wr && reg_addr == 4'h1;   // control write
   wire        div1 = ctl[2] && ctl[1:0] == 2'h0 && !reg_wr; // running undivided, no write

   // shadows follow writes; the design takes writes on the same edge
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ctl <= 8'h00;
         per <= 8'hFF;
         en  <= 1'b0;
      end else if (reg_wr) begin
         if (reg_addr == 4'h1) ctl <= reg_wdata;
         if (reg_addr == 4'h2) per <= reg_wdata;
         if (reg_addr == 4'h3) en <= reg_wdata[1];
      end
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);

   a_ctl_top: assert property (reg_rd && reg_addr == 4'h1 |=> !reg_rdata[7])
      else $error("control top bit read as one");
   a_cnt_load: assert property (wcnt |=> pwm_count == $past(reg_wdata))
      else $error("count write not loaded");
   a_ctl_keep: assert property (wctl |=> $stable(pwm_count))
      else $error("control write changed count");
   a_stop_hold: assert property (!ctl[2] && !wcnt |=> $stable(pwm_count))
      else $error("count moved while stopped");
   a_step_one: assert property (div1 && pwm_count != per |=> pwm_count == $past(pwm_count) + 8'h01)
      else $error("count did not step by one");
   a_match_wrap: assert property (div1 && pwm_count == per |=> pwm_count == 8'h00 && sync_serial_port_tick)
      else $error("no wrap at period match");
   a_tick_pair: assert property (sync_serial_port_tick == pwm_period_wrap)
      else $error("match outputs disagree");
   a_wrap_zero: assert property (pwm_period_wrap |-> pwm_count == 8'h00)
      else $error("wrap pulse without zero count");
   a_irq_req: assert property (match_irq_req == (match_irq_flag && en))
      else $error("request not flag and enable");
   a_flag_hold: assert property (match_irq_flag && !(reg_wr && reg_addr == 4'h3) |=> match_irq_flag)
      else $error("flag dropped without software");
endmodule : pmt8_timer_props

`default_nettype wire

// ===== tb/pmt8_far_model.sv
`timescale 1ns/1ps
`default_nettype none

// far side: serial shift clock and pwm pin fed by the timer
module pmt8_far_model (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       srst,
   // timer events
   input  wire logic       shift_tick,
   input  wire logic       wrap,
   input  wire logic [7:0] count,
   input  wire logic [7:0] duty,
   // serial clock and pwm pin
   output logic            shift_clk,
   output logic            pwm_out
);
   // shift clock toggles per raw match, so it runs at half the match rate
   always_ff @(posedge ref_clk) begin
      if (srst) shift_clk <= 1'b0;
      else if (shift_tick) shift_clk <= !shift_clk;
   end

   // pwm pin set at period start, cleared at the duty compare
   always_ff @(posedge ref_clk) begin
      if (srst) pwm_out <= 1'b0;
      else if (wrap) pwm_out <= 1'b1;
      else if (count == duty) pwm_out <= 1'b0;
   end
endmodule : pmt8_far_model

`default_nettype wire

// ===== tb/pmt8_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none

// self-checking bench for the period match timer
module pmt8_timer_tb;
   logic       ref_clk   = 1'b0;  // 50 MHz
   logic       srst      = 1'b1;  // held 8 cycles
   logic [3:0] reg_addr  = 4'h0;  // register port drive
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr    = 1'b0;
   logic       reg_rd    = 1'b0;
   wire  [7:0] reg_rdata;
   wire  [7:0] cnt;
   wire        tick, wrap, flag, req, sclk, pwm;
   logic [3:0] ps[3] = '{4'h0, 4'hF, 4'h0};  // postscale cases
   logic [7:0] v, p;
   int         errors = 0;
   int         total_checks = 0;
   int         seed = 21;
   int         cyc = 0;
   int         k, n;

   always #10 ref_clk = !ref_clk;

   pmt8_timer pmt8_timer_i (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sync_serial_port_tick(tick),
      .pwm_period_wrap(wrap), .pwm_count(cnt), .match_irq_flag(flag), .match_irq_req(req));
   pmt8_far_model pmt8_far_model_i (.ref_clk(ref_clk), .srst(srst), .shift_tick(tick), .wrap(wrap),
      .count(cnt), .duty(8'h01), .shift_clk(sclk), .pwm_out(pwm));

   // verdict and end of run
   task automatic test_done;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : test_done

   // hang guard, well above the longest sequence
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         test_done;
      end
   end

   // expected cycles between raw matches
   function automatic logic [7:0] gap(input int s, input logic [7:0] per);
      return 8'((s == 0 ? 1 : s == 1 ? 4 : 16) * (per + 1));
   endfunction : gap

   // one comparison
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // one-cycle write
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // one-cycle read, data checked in the following cycle only
   task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk(nm, e, reg_rdata);
   endtask : rd

   // bounded wait for a raw match, returns cycles waited
   task automatic wt(output int c);
      c = 0;
      do begin
         @(posedge ref_clk);
         #1 c++;
      end while (tick !== 1'b1 && c < 600);
   endtask : wt

   // bounded wait for the count to move, returns cycles waited
   task automatic wc(output int c);
      logic [7:0] o;
      #1 o = cnt;
      c = 0;
      do begin
         @(posedge ref_clk);
         #1 c++;
      end while (cnt === o && c < 40);
   endtask : wc

   initial begin
      repeat (8) @(posedge ref_clk);
      srst <= 1'b0;
      rd(4'h0, 8'h00, "count rst");
      rd(4'h1, 8'h00, "control rst");
      rd(4'h2, 8'hFF, "period rst");
      rd(4'h3, 8'h00, "irq rst");
      rd(4'hF, 8'h00, "unmapped");
      wr(4'h1, 8'h80);
      rd(4'h1, 8'h00, "control top");
      v = 8'($random(seed));
      wr(4'h0, v);
      rd(4'h0, v, "count rw");
      $display("test registers done");
      // raw match spacing for every prescale code, random period
      for (int s = 0; s < 4; s++) begin
         p = 8'($random(seed) & 7);
         wr(4'h1, 8'h00);
         wr(4'h2, p);
         wr(4'h0, 8'h00);
         wr(4'h1, 8'h04 | 8'(s));
         wt(k);
         v = {7'h00, sclk};
         wt(k);
         chk("interval", gap(s, p), 8'(k));
         chk("shift clk", ~v & 8'h01, {7'h00, sclk});
      end
      $display("test prescale done");
      // writes restart the divide-by-16 phase; control write keeps count
      wr(4'h2, 8'hFF);
      wr(4'h0, 8'($random(seed) & 8'h7F));
      wc(k);
      chk("count write step", 8'h10, 8'(k));
      repeat (5) @(posedge ref_clk);
      #1 v = cnt;
      wr(4'h1, 8'h07);
      #1 chk("count kept", v, cnt);
      wc(k);
      chk("control write step", 8'h10, 8'(k));
      // period below count: roll through FFh and zero before the match
      wr(4'h1, 8'h00);
      wr(4'h2, 8'h02);
      wr(4'h0, 8'hFE);
      wr(4'h1, 8'h04);
      wt(k);
      chk("rollover match", 8'h05, 8'(k));
      $display("test scaler clear done");
      // matches per flag at both ends of the postscale field and one random
      ps[2] = 4'($random(seed));
      foreach (ps[i]) begin
         wr(4'h1, 8'h00);
         wr(4'h2, 8'h03);
         wr(4'h0, 8'h00);
         wr(4'h3, 8'h02);
         wr(4'h1, {1'b0, ps[i], 3'b100});
         n = 0;
         do begin
            @(posedge ref_clk);
            #1 if (tick === 1'b1) n++;
         end while (flag !== 1'b1 && n < 20);
         chk("post matches", 8'(ps[i]) + 8'h01, 8'(n));
         chk("irq req", 8'h01, {7'h00, req});
         @(posedge ref_clk);
         #1 chk("pwm set", 8'h01, {7'h00, pwm});
         @(posedge ref_clk);
         #1 chk("pwm clear", 8'h00, {7'h00, pwm});
      end
      $display("test postscale done");
      // flag stays until software clears it; request masked by enable
      wr(4'h1, 8'h00);
      repeat (4) @(posedge ref_clk);
      rd(4'h3, 8'h03, "flag held");
      wr(4'h3, 8'h00);
      rd(4'h3, 8'h00, "flag clear");
      wr(4'h3, 8'h01);
      #1 chk("req masked", 8'h00, {7'h00, req});
      $display("test irq done");
      test_done;
   end
endmodule : pmt8_timer_tb

bind pmt8_timer pmt8_timer_props pmt8_timer_props_i (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .sync_serial_port_tick(sync_serial_port_tick), .pwm_period_wrap(pwm_period_wrap), .pwm_count(pwm_count),
   .match_irq_flag(match_irq_flag), .match_irq_req(match_irq_req));

`default_nettype wire
